// ==== hw/tap_prog_device.sv ====
// Device end: test controller with programming data registers.
`timescale 1ns/10ps
`default_nettype none
`include "tap_prog_params.svh"
// ============================================================
// Overview of operation
// - Programmer uses only four test pins
// - Port usable when fuse set, disable clear
// - Reset low clears disable after two clocks
// - All shift registers shift LSB first
// - Instruction register is four bits wide
// - Run-Test/Idle makes execution clocks, idles
// - Opcode c selects one-bit reset chain
// - Chain one holds device in reset
// - Reset persists for time-out after release
// - Opcode 4 unlock register, compare on update
// - Signature a370, unlock cleared at power-on
// - Programmer clears unlock when leaving; host here leaves it set
// - Opcode 5 command register captures result
// - Command shifts, applies, each idle clock executes
// - Opcode 6 byte register is command low
// - Fill update starts buffer write, 11 ticks
// - Fill alternates low then high bytes
// - Fill pre-increments address except first
// - Opcode 7 captures page bytes low first
// - Capture post-increments after every high byte
// - Programmer resets part before unlocking
// - Programmer keeps test clock below maximum
module tap_prog_device #(
    parameter int ADDR_W = 6,
    parameter logic [15:0] RESET_TIMEOUT = `RESET_TIMEOUT_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Test link.
    tap_link_if.device link,
    // Chip side.
    input wire logic port_enable_fuse,
    input wire logic ext_reset_n,
    input wire logic disable_set,
    output logic test_port_disable_bit,
    output logic chip_reset,
    output logic prog_mode,
    output logic [`CMD_W-1:0] flash_cmd,
    output logic flash_cmd_strobe,
    output logic exec_clock,
    output logic [ADDR_W-1:0] word_addr,
    output logic buf_we,
    output logic buf_high,
    output logic [`BYTE_W-1:0] buf_data,
    input wire logic [`CMD_W-1:0] cmd_result,
    input wire logic [2*`BYTE_W-1:0] flash_word
);
    import tap_prog_pkg::*;
    initial begin
        if (ADDR_W < 1 || ADDR_W > 16) $error("ADDR_W out of range");
    end
    typedef struct packed {
        logic [2:0] tck_s, tms_s, tdi_s;
        tap_state_e st;
        logic [`IR_W-1:0] ir_sh, ir;
        logic rst_chain;
        logic [`UNLOCK_W-1:0] unlock;
        logic [`CMD_W-1:0] cmd;
        logic bypass;
        logic tdo;
        logic tdo_oe_n;
        logic dis;
        logic [1:0] dis_cnt;
        logic [15:0] to_cnt;
        logic prog;
        logic [`CMD_W-1:0] fcmd;
        logic fstb, exe;
        logic [ADDR_W-1:0] addr;
        logic fill_high, fill_first, cap_high;
        logic [3:0] wr_cnt;
        logic [`BYTE_W-1:0] tmp;
        logic tmp_high, we;
    } dev_s;
    dev_s s_r, s_nxt;
    logic rise, fall, port_on;
    // Synchroniser stages 0 and 1; edges read only stages 1 and 2.
    assign rise = s_r.tck_s[1] && !s_r.tck_s[2];
    assign fall = !s_r.tck_s[1] && s_r.tck_s[2];
    assign port_on = port_enable_fuse && !s_r.dis;
    // ============================================================
    // Next-state logic.
    always_comb begin
        s_nxt = s_r;
        s_nxt.tck_s = {s_r.tck_s[1:0], link.tck};
        s_nxt.tms_s = {s_r.tms_s[1:0], link.tms};
        s_nxt.tdi_s = {s_r.tdi_s[1:0], link.tdi};
        s_nxt.fstb = 1'b0;
        s_nxt.exe = 1'b0;
        s_nxt.we = 1'b0;
        if (disable_set) begin
            s_nxt.dis = 1'b1;
            s_nxt.dis_cnt = '0;
        end else if (s_r.dis && !ext_reset_n) begin
            s_nxt.dis_cnt = s_r.dis_cnt + 2'h1;
            if (s_nxt.dis_cnt == `PORT_DISABLE_CLR_CLOCKS) s_nxt.dis = 1'b0;
        end else begin
            s_nxt.dis_cnt = '0;
        end
        if (s_r.rst_chain) s_nxt.to_cnt = RESET_TIMEOUT;
        else if (s_r.to_cnt != '0) s_nxt.to_cnt = s_r.to_cnt - 16'h1;
        // Buffer write completes a fixed number of test clocks after update.
        // delayed write
        if (rise && s_r.wr_cnt != '0) begin
            s_nxt.wr_cnt = s_r.wr_cnt - 4'h1;
            if (s_r.wr_cnt == 4'h1) s_nxt.we = 1'b1;
        end
        if (!port_on) begin
            s_nxt.st = st_reset;
        end else if (rise) begin
            // Data shifts on rising edges, LSB first.
            unique case (s_r.st)
                // reset chain capture leaves controller alone
                st_cap_dr: begin
                    if (s_r.ir == `OP_COMMAND) s_nxt.cmd = cmd_result;
                    if (s_r.ir == `OP_PAGE_CAPTURE) begin
                        s_nxt.cmd[`BYTE_W-1:0] = s_r.cap_high ?
                            flash_word[2*`BYTE_W-1:`BYTE_W] : flash_word[`BYTE_W-1:0];
                        s_nxt.cap_high = !s_r.cap_high;
                        if (s_r.cap_high) s_nxt.addr = s_r.addr + 1'b1;
                    end
                    s_nxt.bypass = 1'b0;
                end
                st_sh_dr: begin
                    unique case (s_r.ir)
                        `OP_RESET_CHAIN: s_nxt.rst_chain = s_r.tdi_s[2];
                        `OP_UNLOCK: s_nxt.unlock = {s_r.tdi_s[2], s_r.unlock[`UNLOCK_W-1:1]};
                        `OP_COMMAND: s_nxt.cmd = {s_r.tdi_s[2], s_r.cmd[`CMD_W-1:1]};
                        // byte register is command low bits
                        `OP_PAGE_FILL, `OP_PAGE_CAPTURE:
                            s_nxt.cmd[`BYTE_W-1:0] = {s_r.tdi_s[2], s_r.cmd[`BYTE_W-1:1]};
                        default: s_nxt.bypass = s_r.tdi_s[2];
                    endcase
                end
                st_upd_dr: begin
                    if (s_r.ir == `OP_UNLOCK) s_nxt.prog = s_r.unlock == `UNLOCK_SIGNATURE;
                    if (s_r.ir == `OP_COMMAND) begin
                        s_nxt.fcmd = s_r.cmd;
                        s_nxt.fstb = 1'b1;
                    end
                    if (s_r.ir == `OP_PAGE_FILL) begin
                        s_nxt.tmp = s_r.cmd[`BYTE_W-1:0];
                        s_nxt.tmp_high = s_r.fill_high;
                        s_nxt.fill_high = !s_r.fill_high;
                        if (!s_r.fill_high && !s_r.fill_first) s_nxt.addr = s_r.addr + 1'b1;
                        s_nxt.fill_first = 1'b0;
                        s_nxt.wr_cnt = `PAGE_WRITE_TCK;
                    end
                end
                st_sh_ir: s_nxt.ir_sh = {s_r.tdi_s[2], s_r.ir_sh[`IR_W-1:1]};
                st_upd_ir: begin
                    s_nxt.ir = s_r.ir_sh;
                    s_nxt.fill_high = 1'b0;
                    s_nxt.fill_first = 1'b1;
                    s_nxt.cap_high = 1'b0;
                end
                st_cap_ir: s_nxt.ir_sh = 4'h1;
                st_idle: if (s_r.ir == `OP_COMMAND) s_nxt.exe = 1'b1;
                st_reset: s_nxt.ir = `OP_BYPASS;
                default: ;
            endcase
            unique case (s_r.st)
                st_reset: s_nxt.st = s_r.tms_s[2] ? st_reset : st_idle;
                st_idle: s_nxt.st = s_r.tms_s[2] ? st_sel_dr : st_idle;
                st_sel_dr: s_nxt.st = s_r.tms_s[2] ? st_sel_ir : st_cap_dr;
                st_cap_dr: s_nxt.st = s_r.tms_s[2] ? st_ex1_dr : st_sh_dr;
                st_sh_dr: s_nxt.st = s_r.tms_s[2] ? st_ex1_dr : st_sh_dr;
                st_ex1_dr: s_nxt.st = s_r.tms_s[2] ? st_upd_dr : st_pause_dr;
                st_pause_dr: s_nxt.st = s_r.tms_s[2] ? st_ex2_dr : st_pause_dr;
                st_ex2_dr: s_nxt.st = s_r.tms_s[2] ? st_upd_dr : st_sh_dr;
                st_upd_dr: s_nxt.st = s_r.tms_s[2] ? st_sel_dr : st_idle;
                st_sel_ir: s_nxt.st = s_r.tms_s[2] ? st_reset : st_cap_ir;
                st_cap_ir: s_nxt.st = s_r.tms_s[2] ? st_ex1_ir : st_sh_ir;
                st_sh_ir: s_nxt.st = s_r.tms_s[2] ? st_ex1_ir : st_sh_ir;
                st_ex1_ir: s_nxt.st = s_r.tms_s[2] ? st_upd_ir : st_pause_ir;
                st_pause_ir: s_nxt.st = s_r.tms_s[2] ? st_ex2_ir : st_pause_ir;
                st_ex2_ir: s_nxt.st = s_r.tms_s[2] ? st_upd_ir : st_sh_ir;
                st_upd_ir: s_nxt.st = s_r.tms_s[2] ? st_sel_dr : st_idle;
                default: s_nxt.st = st_reset;
            endcase
        end else if (fall) begin
            // Output changes on the falling edge, from the register's bit 0.
            s_nxt.tdo_oe_n = !(s_r.st == st_sh_dr || s_r.st == st_sh_ir);
            if (s_r.st == st_sh_ir) s_nxt.tdo = s_r.ir_sh[0];
            else unique case (s_r.ir)
                `OP_RESET_CHAIN: s_nxt.tdo = s_r.rst_chain;
                `OP_UNLOCK: s_nxt.tdo = s_r.unlock[0];
                `OP_COMMAND, `OP_PAGE_FILL, `OP_PAGE_CAPTURE: s_nxt.tdo = s_r.cmd[0];
                default: s_nxt.tdo = s_r.bypass;
            endcase
        end
    end
    // ============================================================
    // State register; the unlock register clears only at power-on reset.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.st <= st_reset;
            s_r.ir <= `OP_BYPASS;
            s_r.tdo_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign chip_reset = s_r.rst_chain || s_r.to_cnt != '0 || !ext_reset_n;
    assign link.tdo = s_r.tdo;
    assign link.tdo_oe_n = s_r.tdo_oe_n;
    assign test_port_disable_bit = s_r.dis;
    assign prog_mode = s_r.prog;
    assign flash_cmd = s_r.fcmd;
    assign flash_cmd_strobe = s_r.fstb;
    assign exec_clock = s_r.exe;
    assign word_addr = s_r.addr;
    assign buf_we = s_r.we;
    assign buf_high = s_r.tmp_high;
    assign buf_data = s_r.tmp;
endmodule // tap_prog_device
`default_nettype wire

// ==== hw/tap_prog_params.svh ====
// Constants for the test-port programming block.
`ifndef TAP_PROG_PARAMS_SVH
`define TAP_PROG_PARAMS_SVH
`define IR_W 4
`define OP_RESET_CHAIN 4'hc
`define OP_UNLOCK 4'h4
`define OP_COMMAND 4'h5
`define OP_PAGE_FILL 4'h6
`define OP_PAGE_CAPTURE 4'h7
`define OP_BYPASS 4'hf
`define UNLOCK_W 16
`define UNLOCK_SIGNATURE 16'ha370
`define CMD_W 15
`define BYTE_W 8
`define PORT_DISABLE_CLR_CLOCKS 2'h2
`define PAGE_WRITE_TCK 4'hb
`define RESET_TIMEOUT_CYCLES 16'h0040
`define TCK_HALF_DIV 8'h05
`endif

// ==== hw/tap_prog_pkg.sv ====
// Types shared by both ends of the test-port programming link.
package tap_prog_pkg;
    // Test controller states, gray-coded along the usual scan path.
    typedef enum logic [3:0] {
        st_reset = 4'h0, st_idle = 4'h1, st_sel_dr = 4'h3, st_cap_dr = 4'h2,
        st_sh_dr = 4'h6, st_ex1_dr = 4'h7, st_pause_dr = 4'h5, st_ex2_dr = 4'h4,
        st_upd_dr = 4'hc, st_sel_ir = 4'hd, st_cap_ir = 4'hf, st_sh_ir = 4'he,
        st_ex1_ir = 4'ha, st_pause_ir = 4'hb, st_ex2_ir = 4'h9, st_upd_ir = 4'h8
    } tap_state_e;
    // Programmer phases.
    typedef enum logic [2:0] {
        hp_idle = 3'h0, hp_load = 3'h1, hp_low = 3'h3, hp_high = 3'h2, hp_done = 3'h6
    } host_phase_e;
endpackage

// ==== hw/tap_link_if.sv ====
// Four-wire test-port link between programmer and device.
`timescale 1ns/10ps
`default_nettype none
interface tap_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    modport programmer (output tck, output tms, output tdi, input tdo);
    modport device (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
endinterface
`default_nettype wire

// ==== hw/stream_fifo.sv ====
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r, rp_r;
    // Full when pointers differ only in the wrap bit.
    assign in_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
    assign out_valid = wp_r != rp_r;
    assign out_data = mem[rp_r[AW-1:0]];
    // Pointers advance on each accepted transfer.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                mem[wp_r[AW-1:0]] <= in_data;
                wp_r <= wp_r + 1'b1;
            end
            if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
        end
    end
endmodule // stream_fifo
`default_nettype wire

// ==== hw/tap_prog_host.sv ====
// Programmer end: resets, unlocks and streams page bytes from a FIFO.
`timescale 1ns/10ps
`default_nettype none
`include "tap_prog_params.svh"
module tap_prog_host #(
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Test link.
    tap_link_if.programmer link,
    // Byte stream to load.
    input wire logic byte_valid,
    output logic byte_ready,
    input wire logic [`BYTE_W-1:0] byte_data,
    // Control.
    input wire logic start,
    output logic busy
);
    import tap_prog_pkg::*;
    // Scan job: tms bits and tdi bits, sent LSB first, one per test clock.
    typedef struct packed {
        logic [7:0] div;
        logic tck;
        host_phase_e ph;
        logic [5:0] left;
        logic [47:0] tms;
        logic [47:0] tdi;
        logic tdo_s1, tdo_s2;
    } host_s;
    host_s s_r, s_nxt;
    logic f_valid, f_ready;
    logic [`BYTE_W-1:0] f_data;
    // A stalled link holds bytes here; byte_ready drops when full.
    stream_fifo #(.WIDTH(`BYTE_W), .DEPTH(DEPTH)) fifo (
        .clock(clock), .rstn(rstn),
        .in_valid(byte_valid), .in_ready(byte_ready), .in_data(byte_data),
        .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data)
    );
    logic tick;
    assign tick = s_r.div == `TCK_HALF_DIV;
    // A byte is taken when a new fill scan is loaded.
    assign f_ready = s_r.ph == hp_high && s_r.left == '0 && tick && s_r.tck;
    // ============================================================
    // Scan sequencer.
    always_comb begin
        s_nxt = s_r;
        s_nxt.tdo_s1 = link.tdo;
        s_nxt.tdo_s2 = s_r.tdo_s1;
        s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
        if (tick) begin
            s_nxt.tck = !s_r.tck;
            if (s_r.tck && s_r.left != '0) begin
                s_nxt.tms = {1'b0, s_r.tms[47:1]};
                s_nxt.tdi = {1'b0, s_r.tdi[47:1]};
                s_nxt.left = s_r.left - 6'h1;
            end else if (s_r.tck && s_r.left == '0) begin
                unique case (s_r.ph)
                    hp_idle: if (start) begin
                        s_nxt.tms = 48'h0000_0000_3383;
                        s_nxt.tdi = 48'h0000_0000_10c0;
                        s_nxt.left = 6'h0e;
                        s_nxt.ph = hp_load;
                    end
                    hp_load: begin
                        s_nxt.tms = 48'h0030_7800_0383;
                        s_nxt.tdi = {11'h0, `OP_PAGE_FILL, 5'h0, `UNLOCK_SIGNATURE, 4'h0,
                            `OP_UNLOCK, 4'h0};
                        s_nxt.left = 6'h26;
                        s_nxt.ph = hp_high;
                    end
                    hp_high: if (f_valid) begin
                        s_nxt.tms = 48'h0000_0000_0c01;
                        s_nxt.tdi = {37'h0, f_data, 3'h0};
                        s_nxt.left = 6'h0c;
                    end else if (!start) begin
                        s_nxt.ph = hp_done;
                    end
                    hp_done: if (!start) s_nxt.ph = hp_idle;
                    default: s_nxt.ph = hp_idle;
                endcase
            end
        end
    end
    // ============================================================
    // State register.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.ph <= hp_idle;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign link.tck = s_r.tck;
    assign link.tms = s_r.tms[0];
    assign link.tdi = s_r.tdi[0];
    assign busy = s_r.ph != hp_idle;
endmodule // tap_prog_host
`default_nettype wire

// ==== testbench/tap_link_checker.sv ====
// Assertions on the host-to-device link and the device chip side.
`timescale 1ns/10ps
`default_nettype none
module tap_link_checker #(
    parameter int ADDR_W = 6
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Link.
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    // Device chip side.
    input wire logic port_enable_fuse,
    input wire logic ext_reset_n,
    input wire logic test_port_disable_bit,
    input wire logic chip_reset,
    input wire logic prog_mode,
    input wire logic buf_we,
    input wire logic buf_high,
    input wire logic [ADDR_W-1:0] word_addr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ============================================================
    // Last page write, so that each write is judged against the one before it.
    logic seen_r;
    logic last_high_r;
    logic [ADDR_W-1:0] last_addr_r;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            seen_r <= 1'b0;
            last_high_r <= 1'b0;
            last_addr_r <= '0;
        end else if (buf_we) begin
            seen_r <= 1'b1;
            last_high_r <= buf_high;
            last_addr_r <= word_addr;
        end
    end
    // ============================================================
    // Page fill writes.
    // single write pulse
    a_write_one_pulse: assert property (buf_we |=> !buf_we)
        else $error("page write strobe held");
    a_fill_starts_low: assert property (buf_we && !seen_r |-> !buf_high)
        else $error("first fill write not low byte");
    a_fill_alternates: assert property (buf_we && seen_r |-> buf_high != last_high_r)
        else $error("fill bytes did not alternate");
    a_high_same_addr: assert property (buf_we && buf_high && seen_r |-> word_addr == last_addr_r)
        else $error("high byte moved address");
    a_low_next_addr: assert property (
        buf_we && !buf_high && seen_r |-> word_addr == last_addr_r + 1'b1)
        else $error("low byte address not advanced by one");
    // ============================================================
    // Reset, gating and link behaviour.
    // external reset mirrored
    a_ext_reset_chip: assert property (!ext_reset_n |-> chip_reset)
        else $error("chip not in reset with external reset low");
    a_disable_clear: assert property (
        $fell(ext_reset_n) && test_port_disable_bit |-> ##2 !test_port_disable_bit)
        else $error("disable bit not cleared two clocks after reset");
    a_unlock_gated: assert property (
        $rose(prog_mode) |-> port_enable_fuse && !test_port_disable_bit)
        else $error("programming entered on a disabled port");
    a_unlock_in_reset: assert property ($rose(prog_mode) |-> chip_reset)
        else $error("programming entered outside reset");
    a_tdo_quiet: assert property ((!tck)[*6] |-> $stable(tdo) && $stable(tdo_oe_n))
        else $error("data out changed while test clock idle low");
    // Main scenarios reached.
    c_high_write: cover property (buf_we && buf_high);
    c_unlocked: cover property ($rose(prog_mode));
    c_disable_cleared: cover property ($fell(test_port_disable_bit));
endmodule // tap_link_checker
`default_nettype wire

// ==== testbench/tb.sv ====
// Bench: host joined to one device, plus a second device scanned by the bench.
`timescale 1ns/10ps
`default_nettype none
`include "tap_prog_params.svh"
`define CHECK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module tb;
    // ============================================================
    // Shared inputs; suffix a is the host-joined device, b the bench-scanned one.
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic port_enable_fuse = 1'b1;
    logic ext_reset_n = 1'b1;
    logic disable_set = 1'b0;
    logic [14:0] cmd_result = 15'h2b4d;
    logic byte_valid = 1'b0;
    logic start = 1'b0;
    logic [7:0] byte_data = 8'h00;
    logic byte_ready, busy, dis_a, dis_b, rst_a, rst_b, prog_a, prog_b;
    logic we_a, we_b, hi_a, hi_b, strobe_b, exec_b;
    logic [5:0] addr_a, addr_b;
    logic [7:0] data_a, data_b;
    logic [14:0] cmd_b;
    logic [15:0] word_a, word_b, q;
    logic [14:0] log_a[$], log_b[$];
    logic [7:0] fill_bytes[4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    int strobes = 0, execs = 0, fail_count = 0, checks_done = 0;
    tap_link_if link_a();
    tap_link_if link_b();
    // Flash words tell their own address, so a read from a wrong word shows.
    assign word_a = {2'b10, addr_a, 2'b01, addr_a};
    assign word_b = {2'b10, addr_b, 2'b01, addr_b};
    always #2.5 clock = ~clock;
    // Log page writes and count command pulses.
    always @(posedge clock) begin
        if (we_a) log_a.push_back({hi_a, addr_a, data_a});
        if (we_b) log_b.push_back({hi_b, addr_b, data_b});
        strobes <= strobes + int'(strobe_b);
        execs <= execs + int'(exec_b);
    end
    tap_prog_host u_tap_prog_host (.clock(clock), .rstn(rstn), .link(link_a),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data),
        .start(start), .busy(busy));
    tap_prog_device u_tap_prog_device (.clock(clock), .rstn(rstn), .link(link_a),
        .port_enable_fuse(port_enable_fuse), .ext_reset_n(ext_reset_n),
        .disable_set(disable_set), .test_port_disable_bit(dis_a), .chip_reset(rst_a),
        .prog_mode(prog_a), .flash_cmd(), .flash_cmd_strobe(), .exec_clock(),
        .word_addr(addr_a), .buf_we(we_a), .buf_high(hi_a), .buf_data(data_a),
        .cmd_result(cmd_result), .flash_word(word_a));
    tap_prog_device u_tap_prog_device_b (.clock(clock), .rstn(rstn), .link(link_b),
        .port_enable_fuse(port_enable_fuse), .ext_reset_n(ext_reset_n),
        .disable_set(disable_set), .test_port_disable_bit(dis_b), .chip_reset(rst_b),
        .prog_mode(prog_b), .flash_cmd(cmd_b), .flash_cmd_strobe(strobe_b),
        .exec_clock(exec_b), .word_addr(addr_b), .buf_we(we_b), .buf_high(hi_b),
        .buf_data(data_b), .cmd_result(cmd_result), .flash_word(word_b));
    tap_link_checker #(.ADDR_W(6)) u_tap_link_checker (.clock(clock), .rstn(rstn),
        .tck(link_a.tck), .tdo(link_a.tdo), .tdo_oe_n(link_a.tdo_oe_n),
        .port_enable_fuse(port_enable_fuse), .ext_reset_n(ext_reset_n),
        .test_port_disable_bit(dis_a), .chip_reset(rst_a), .prog_mode(prog_a),
        .buf_we(we_a), .buf_high(hi_a), .word_addr(addr_a));
    // ============================================================
    // Verdict, and the way out when a wait runs dry.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic bail(input string what);
        fail_count++;
        $display("unexpected at %0t: %s", $time, what);
        finish_test();
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One 48 ns test-clock period; mode and data change only while the clock is low.
    task automatic tick(input logic m, input logic d, output logic o);
        link_b.tms = m;
        link_b.tdi = d;
        #24;
        o = link_b.tdo;
        link_b.tck = 1'b1;
        #24;
        link_b.tck = 1'b0;
    endtask
    task automatic idle(input int n);
        logic o;
        repeat (n) tick(1'b0, 1'b0, o);
    endtask
    // Idle to idle scan, least significant bit first, captured bits into q.
    task automatic scan(input logic ir, input int n, input logic [15:0] v);
        logic o;
        tick(1'b1, 1'b0, o);
        if (ir) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        q = '0;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[i], o);
            q[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
    // ============================================================
    // Scenarios.
    task automatic t_gate();
        port_enable_fuse = 1'b0;
        scan(1'b1, 4, 16'(`OP_UNLOCK));
        scan(1'b0, 16, `UNLOCK_SIGNATURE);
        `CHECK(prog_b, 1'b0)
        @(negedge clock);
        port_enable_fuse = 1'b1;
        disable_set = 1'b1;
        @(negedge clock);
        disable_set = 1'b0;
        cycles(2);
        `CHECK(dis_b, 1'b1)
        ext_reset_n = 1'b0;
        cycles(3);
        `CHECK(dis_b, 1'b0)
        `CHECK(rst_b, 1'b1)
        ext_reset_n = 1'b1;
        idle(1);
        $display("gate test done");
    endtask
    task automatic t_chain();
        int n;
        scan(1'b1, 4, 16'(`OP_RESET_CHAIN));
        scan(1'b0, 1, 16'h0001);
        `CHECK(rst_b, 1'b1)
        scan(1'b0, 1, 16'h0000);
        `CHECK(rst_b, 1'b1)
        for (n = 0; n < 200 && rst_b !== 1'b0; n++) @(negedge clock);
        if (rst_b !== 1'b0) bail("chip reset never released");
        // Back into reset before unlocking, as the programmer must.
        scan(1'b0, 1, 16'h0001);
        `CHECK(rst_b, 1'b1)
        $display("reset chain test done");
    endtask
    task automatic t_unlock();
        scan(1'b1, 4, 16'(`OP_UNLOCK));
        scan(1'b0, 16, 16'h0ec5);
        `CHECK(prog_b, 1'b0)
        scan(1'b0, 16, `UNLOCK_SIGNATURE);
        `CHECK(prog_b, 1'b1)
        $display("unlock test done");
    endtask
    task automatic t_command();
        int s0, e0;
        scan(1'b1, 4, 16'(`OP_COMMAND));
        s0 = strobes;
        scan(1'b0, 15, 16'h1a3c);
        e0 = execs;
        `CHECK(q[14:0], cmd_result)
        `CHECK(cmd_b, 15'h1a3c)
        `CHECK(strobes - s0, 1)
        idle(3);
        cycles(4);
        `CHECK(execs - e0, 3)
        $display("command test done");
    endtask
    task automatic t_fill();
        scan(1'b1, 4, 16'(`OP_PAGE_FILL));
        for (int k = 0; k < 4; k++) begin
            scan(1'b0, 8, {8'h00, fill_bytes[k]});
            idle(11);
            cycles(4);
            `CHECK(log_b.size(), k + 1)
            `CHECK(log_b[k], {k[0], 6'(k / 2), fill_bytes[k]})
        end
        $display("page fill test done");
    endtask
    task automatic t_capture();
        scan(1'b1, 4, 16'(`OP_PAGE_CAPTURE));
        for (int k = 0; k < 4; k++) begin
            scan(1'b0, 8, 16'h0000);
            `CHECK(q[7:0], {(k % 2 == 1) ? 2'b10 : 2'b01, 6'(1 + k / 2)})
        end
        `CHECK(addr_b, 6'h03)
        $display("page capture test done");
    endtask
    task automatic t_host();
        int n;
        // Fill the buffer until it refuses, with the host not yet draining.
        for (int i = 0; i < 9; i++) begin
            @(negedge clock);
            byte_valid = (i < 8);
            byte_data = 8'h10 + 8'(i);
            `CHECK(byte_ready, i < 8)
        end
        start = 1'b1;
        for (n = 0; n < 100 && busy !== 1'b1; n++) @(negedge clock);
        start = 1'b0;
        for (n = 0; n < 20000 && log_a.size() < 8; n++) @(negedge clock);
        if (log_a.size() != 8) bail("host stream did not complete");
        for (int i = 0; i < 8; i++) begin
            `CHECK(log_a[i], {i[0], 6'(i / 2), 8'h10 + 8'(i)})
        end
        `CHECK(byte_ready, 1'b1)
        `CHECK(prog_a, 1'b1)
        `CHECK(rst_a, 1'b1)
        $display("host stream test done");
    endtask
    // ============================================================
    // Main sequence.
    initial begin
        link_b.tck = 1'b0;
        link_b.tms = 1'b1;
        link_b.tdi = 1'b0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        `CHECK(prog_b, 1'b0)
        t_gate();
        t_chain();
        t_unlock();
        t_command();
        t_fill();
        t_capture();
        t_host();
        finish_test();
    end
endmodule // tb
`default_nettype wire
